// ### core/fas_pkg.sv
// Package: register map, field widths and reset values of the fault alert status bank
package fas_pkg;

   // ------------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------------
   localparam logic [7:0] IDX_AUX_LOW      = 8'h0d;
   localparam logic [7:0] IDX_CMP_CELL_HI  = 8'h0e;
   localparam logic [7:0] IDX_CMP_CELL_LO  = 8'h0f;
   localparam logic [7:0] IDX_CMP_AUX_HI   = 8'h10;
   localparam logic [7:0] IDX_CMP_AUX_LO   = 8'h11;
   localparam logic [7:0] IDX_IRQ_MASK     = 8'h20;
   localparam logic [7:0] IDX_IRQ_STATUS   = 8'h21;
   localparam logic [7:0] IDX_ENABLE_AUX   = 8'h22;
   localparam logic [7:0] IDX_ENABLE_CELL  = 8'h23;

   // ------------------------------------------------------------------
   // Field widths and reset values
   // ------------------------------------------------------------------
   localparam int          NUM_CELLS   = 14;
   localparam int          NUM_AUX     = 4;
   localparam int          NUM_EVENTS  = 5;
   localparam logic [13:0] CELL_RESET  = 14'h0000;
   localparam logic [3:0]  AUX_RESET   = 4'h0;
   localparam logic [4:0]  EVT_RESET   = 5'h00;
   localparam logic [31:0] BAD_READ    = 32'h0000_0000;

   // ------------------------------------------------------------------
   // Bus slave states
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      FAS_IDLE = 2'b01,
      FAS_DONE = 2'b10
   } fas_bus_state_t;

endpackage : fas_pkg

// ### core/fas_flag_if.sv
// Interface: one acquisition result group passed to a flag bank
`timescale 1ns/1ps
interface fas_flag_if #(parameter int W = 4);
   logic         done;
   logic [W-1:0] fault;
   logic [W-1:0] enable;
   logic [W-1:0] flags;
   logic         changed;
   modport src  (output done, output fault, output enable, input flags, input changed);
   modport bank (input done, input fault, input enable, output flags, output changed);
endinterface : fas_flag_if

// ### core/fas_flag_bank.sv
// Module: per-channel alert flags refreshed at each acquisition
`timescale 1ns/1ps
module fas_flag_bank #(
   parameter int W = 4
) (
   input  wire logic clk,
   input  wire logic reset,
   fas_flag_if.bank  fi
);
   // Refuse widths that the read mux cannot place in one register
   if (W < 1 || W > 16) begin : g_bad_width
      $error("fas_flag_bank: width out of range");
   end

   logic [W-1:0] flags_q;
   logic [W-1:0] flags_d;
   logic         chg_q;
   logic         chg_d;

   // Flag follows the qualified fault only at acquisition; holds otherwise
   always_comb begin
      flags_d = flags_q;
      chg_d   = 1'b0;
      if (fi.done) begin
         flags_d = fi.fault & fi.enable;
         chg_d   = |(flags_d & ~flags_q);
      end
   end

   // Flags clear to zero on reset
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         flags_q <= '0;
         chg_q   <= 1'b0;
      end else begin
         flags_q <= flags_d;
         chg_q   <= chg_d;
      end
   end

   assign fi.flags   = flags_q;
   assign fi.changed = chg_q;
endmodule : fas_flag_bank

// ### core/fas_status_bank.sv
// Top: fault alert status registers with Avalon-MM slave and alert interrupt
//
// Behaviour
// (R01) An aux low flag sets when its input is below the aux low threshold and its aux low enable is one.
// (R02) Each aux low flag, measured or comparator, clears at the next acquisition if the input is no longer low.
// (R03) Fourteen comparator cell high flags in bits 13:0, bit n-1 for cell n, set when high and enabled.
// (R04) A comparator cell high flag clears only at the next comparator acquisition once no longer high.
// (R05) Fourteen comparator cell low flags in bits 13:0 set when the cell is low and its low enable is one.
// (R06) A comparator cell low flag clears at the next comparator acquisition once no longer low.
// (R07) A comparator aux high flag sets when the aux input is above threshold and aux high enable is one.
// (R08) A comparator aux high flag clears at the next comparator acquisition once no longer high.
// (R09) A comparator aux low flag sets when the aux input is below threshold and aux low enable is one.
// (R10) The five alert registers are read only and all flags reset to zero.
// (R11) Unimplemented bits of the alert registers read zero and writes to them are ignored.
// (R12) Flags change only when the matching acquisition completes and hold between acquisitions.
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ps
module fas_status_bank (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic      [1:0]  avs_response,
   output logic             avs_waitrequest,
   input  wire logic        meas_done,
   input  wire logic        cmp_done,
   input  wire logic [3:0]  aux_meas_low,
   input  wire logic [13:0] cmp_cell_high,
   input  wire logic [13:0] cmp_cell_low,
   input  wire logic [3:0]  cmp_aux_high,
   input  wire logic [3:0]  cmp_aux_low,
   output logic             irq
);
   // ------------------------------------------------------------------
   // Enable registers and flag banks
   // ------------------------------------------------------------------
   logic [3:0]  aux_low_alert_enable_q,  aux_low_alert_enable_d;
   logic [3:0]  aux_high_alert_enable_q, aux_high_alert_enable_d;
   logic [13:0] cell_high_alert_enable_q, cell_high_alert_enable_d;
   logic [13:0] cell_low_alert_enable_q,  cell_low_alert_enable_d;

   fas_flag_if #(.W(4))  aux_low_i ();
   fas_flag_if #(.W(14)) cell_hi_i ();
   fas_flag_if #(.W(14)) cell_lo_i ();
   fas_flag_if #(.W(4))  aux_hi_i ();
   fas_flag_if #(.W(4))  caux_lo_i ();

   // (R01) measured aux low
   // (R12) measured path refreshes on measurement completion
   assign aux_low_i.done   = meas_done;
   assign aux_low_i.fault  = aux_meas_low;
   assign aux_low_i.enable = aux_low_alert_enable_q;
   // (R03) cell high per cell
   // (R12) comparator paths refresh on comparator completion
   assign cell_hi_i.done   = cmp_done;
   assign cell_hi_i.fault  = cmp_cell_high;
   assign cell_hi_i.enable = cell_high_alert_enable_q;
   // (R05) cell low per cell
   assign cell_lo_i.done   = cmp_done;
   assign cell_lo_i.fault  = cmp_cell_low;
   assign cell_lo_i.enable = cell_low_alert_enable_q;
   // (R07) aux high comparator
   assign aux_hi_i.done    = cmp_done;
   assign aux_hi_i.fault   = cmp_aux_high;
   assign aux_hi_i.enable  = aux_high_alert_enable_q;
   // (R09) aux low comparator
   assign caux_lo_i.done   = cmp_done;
   assign caux_lo_i.fault  = cmp_aux_low;
   assign caux_lo_i.enable = aux_low_alert_enable_q;

   // (R02) clear on next acquisition handled in each bank
   // (R04) (R06) (R08) comparator flags follow fault at comparator done
   fas_flag_bank #(.W(4))  u_aux_low  (.clk(clk), .reset(reset), .fi(aux_low_i));
   fas_flag_bank #(.W(14)) u_cell_hi  (.clk(clk), .reset(reset), .fi(cell_hi_i));
   fas_flag_bank #(.W(14)) u_cell_lo  (.clk(clk), .reset(reset), .fi(cell_lo_i));
   fas_flag_bank #(.W(4))  u_aux_hi   (.clk(clk), .reset(reset), .fi(aux_hi_i));
   fas_flag_bank #(.W(4))  u_caux_lo  (.clk(clk), .reset(reset), .fi(caux_lo_i));

   // ------------------------------------------------------------------
   // Bus slave, interrupt status and mask
   // ------------------------------------------------------------------
   fas_pkg::fas_bus_state_t st_q, st_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0]  resp_q, resp_d;
   logic        wait_q, wait_d;
   logic [4:0]  evt_q, evt_d;
   logic [4:0]  mask_q, mask_d;
   logic        irq_q, irq_d;
   logic [4:0]  evt_in;

   assign evt_in = {caux_lo_i.changed, aux_hi_i.changed, cell_lo_i.changed,
                    cell_hi_i.changed, aux_low_i.changed};

   // One wait cycle per access; answer registered so outputs come from flops
   always_comb begin
      st_d     = st_q;
      rdata_d  = rdata_q;
      resp_d   = resp_q;
      wait_d   = 1'b1;
      evt_d    = evt_q;
      mask_d   = mask_q;
      aux_low_alert_enable_d   = aux_low_alert_enable_q;
      aux_high_alert_enable_d  = aux_high_alert_enable_q;
      cell_high_alert_enable_d = cell_high_alert_enable_q;
      cell_low_alert_enable_d  = cell_low_alert_enable_q;
      case (st_q)
         fas_pkg::FAS_IDLE: begin
            if (avs_read || avs_write) begin
               st_d    = fas_pkg::FAS_DONE;
               wait_d  = 1'b0;
               resp_d  = 2'b00;
               rdata_d = fas_pkg::BAD_READ;
               // (R10) alert registers read only
               // (R11) upper bits zero, writes ignored
               if (avs_address == fas_pkg::IDX_AUX_LOW) begin
                  rdata_d = {28'h0000000, aux_low_i.flags};
               end else if (avs_address == fas_pkg::IDX_CMP_CELL_HI) begin
                  rdata_d = {18'h00000, cell_hi_i.flags};
               end else if (avs_address == fas_pkg::IDX_CMP_CELL_LO) begin
                  rdata_d = {18'h00000, cell_lo_i.flags};
               end else if (avs_address == fas_pkg::IDX_CMP_AUX_HI) begin
                  rdata_d = {28'h0000000, aux_hi_i.flags};
               end else if (avs_address == fas_pkg::IDX_CMP_AUX_LO) begin
                  rdata_d = {28'h0000000, caux_lo_i.flags};
               end else if (avs_address == fas_pkg::IDX_IRQ_MASK) begin
                  rdata_d = {27'h0000000, mask_q};
                  if (avs_write && avs_byteenable[0]) mask_d = avs_writedata[4:0];
               end else if (avs_address == fas_pkg::IDX_IRQ_STATUS) begin
                  rdata_d = {27'h0000000, evt_q};
                  if (avs_read) evt_d = 5'h00;     // Read clears
               end else if (avs_address == fas_pkg::IDX_ENABLE_AUX) begin
                  rdata_d = {24'h000000, aux_high_alert_enable_q, aux_low_alert_enable_q};
                  if (avs_write && avs_byteenable[0]) begin
                     aux_low_alert_enable_d  = avs_writedata[3:0];
                     aux_high_alert_enable_d = avs_writedata[7:4];
                  end
               end else if (avs_address == fas_pkg::IDX_ENABLE_CELL) begin
                  rdata_d = {2'b00, cell_high_alert_enable_q, 2'b00, cell_low_alert_enable_q};
                  if (avs_write) begin
                     if (avs_byteenable[0]) cell_low_alert_enable_d[7:0]   = avs_writedata[7:0];
                     if (avs_byteenable[1]) cell_low_alert_enable_d[13:8]  = avs_writedata[13:8];
                     if (avs_byteenable[2]) cell_high_alert_enable_d[7:0]  = avs_writedata[23:16];
                     if (avs_byteenable[3]) cell_high_alert_enable_d[13:8] = avs_writedata[29:24];
                  end
               end else begin
                  resp_d = 2'b11;                  // Decode error on unmapped index
               end
            end
         end
         fas_pkg::FAS_DONE: begin
            st_d = fas_pkg::FAS_IDLE;
         end
         default: st_d = fas_pkg::FAS_IDLE;
      endcase
      // New events win over a clearing read in the same cycle
      evt_d = evt_d | evt_in;
      irq_d = |(evt_d & mask_d);
   end

   // State registers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_q    <= fas_pkg::FAS_IDLE;
         rdata_q <= fas_pkg::BAD_READ;
         resp_q  <= 2'b00;
         wait_q  <= 1'b1;
         evt_q   <= fas_pkg::EVT_RESET;
         mask_q  <= fas_pkg::EVT_RESET;
         irq_q   <= 1'b0;
         aux_low_alert_enable_q   <= fas_pkg::AUX_RESET;
         aux_high_alert_enable_q  <= fas_pkg::AUX_RESET;
         cell_high_alert_enable_q <= fas_pkg::CELL_RESET;
         cell_low_alert_enable_q  <= fas_pkg::CELL_RESET;
      end else begin
         st_q    <= st_d;
         rdata_q <= rdata_d;
         resp_q  <= resp_d;
         wait_q  <= wait_d;
         evt_q   <= evt_d;
         mask_q  <= mask_d;
         irq_q   <= irq_d;
         aux_low_alert_enable_q   <= aux_low_alert_enable_d;
         aux_high_alert_enable_q  <= aux_high_alert_enable_d;
         cell_high_alert_enable_q <= cell_high_alert_enable_d;
         cell_low_alert_enable_q  <= cell_low_alert_enable_d;
      end
   end

   assign avs_readdata    = rdata_q;
   assign avs_response    = resp_q;
   assign avs_waitrequest = wait_q;
   assign irq             = irq_q;
endmodule : fas_status_bank

// ### verif/fas_status_bank_chk.sv
// Checker: bus handshake, decode and interrupt timing of the status bank
`timescale 1ns/1ps
module fas_status_bank_chk (
   input wire logic        clk,
   input wire logic        reset,
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic [1:0]  avs_response,
   input wire logic        avs_waitrequest,
   input wire logic        meas_done,
   input wire logic        cmp_done,
   input wire logic        irq
);
   logic [3:0] quiet_q;
   logic [3:0] quiet_d;
   logic       ack;
   logic       alrt;
   logic       map;
   // Cycles since anything that may raise irq; saturates so it never wraps
   always_comb begin
      quiet_d = (meas_done | cmp_done | avs_write) ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hf};
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) quiet_q <= 4'hf;
      else quiet_q <= quiet_d;
   end
   // Read answer and address classes
   assign ack  = avs_read & ~avs_waitrequest;
   assign alrt = avs_address inside {[8'h0d:8'h11]};
   assign map  = alrt | (avs_address inside {[8'h20:8'h23]});
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   wait_bound_a: assert property ((avs_read | avs_write) && avs_waitrequest |-> ##[1:3] !avs_waitrequest)
      else $error("no answer within three cycles");
   wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("answer longer than one cycle");
   ans_cause_a: assert property (!avs_waitrequest |-> $past(avs_read | avs_write))
      else $error("answer without request");
   decode_err_a: assert property (ack && !map |-> avs_response == 2'b11 && avs_readdata == 32'h0)
      else $error("unmapped read not refused");
   ro_write_a: assert property (!avs_waitrequest && avs_write && alrt |-> avs_response == 2'b00)
      else $error("alert write not answered okay");
   cell_spare_a: assert property (ack && avs_address inside {8'h0e, 8'h0f} |-> avs_readdata[31:14] == 18'h0)
      else $error("cell register spare bits set");
   aux_spare_a: assert property (ack && avs_address inside {8'h0d, 8'h10, 8'h11} |-> avs_readdata[31:4] == 28'h0)
      else $error("aux register spare bits set");
   irq_cause_a: assert property ($rose(irq) |-> quiet_q <= 4'h6)
      else $error("irq rose with no acquisition");
   reset_out_a: assert property ($fell(reset) |-> !irq && avs_waitrequest)
      else $error("outputs not at reset level");
endmodule : fas_status_bank_chk

bind fas_status_bank fas_status_bank_chk fas_status_bank_chk_inst (.clk(clk), .reset(reset),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_response(avs_response), .avs_waitrequest(avs_waitrequest), .meas_done(meas_done),
   .cmp_done(cmp_done), .irq(irq));

// ### verif/fas_status_bank_tb_top.sv
// Testbench: register reads, acquisitions and alert interrupt of the status bank
`timescale 1ns/1ps
module fas_status_bank_tb_top;
   logic        clk, reset, rd, wr, wrq, md, cd, irq;
   logic [7:0]  adr;
   logic [31:0] wdat, rdat;
   logic [1:0]  resp;
   logic [3:0]  aml, cah, cal, f_ml, f_ah, f_kl, e_al, e_ah;
   logic [13:0] cch, ccl, f_ch, f_cl, e_cl, e_ch;
   logic [33:0] exp_q[$];
   logic [63:0] r;
   int          n_mismatch, check_count, seed;
   fas_status_bank fas_status_bank_inst (.clk(clk), .reset(reset), .avs_address(adr), .avs_read(rd),
      .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(4'hf), .avs_readdata(rdat),
      .avs_response(resp), .avs_waitrequest(wrq), .meas_done(md), .cmp_done(cd),
      .aux_meas_low(aml), .cmp_cell_high(cch), .cmp_cell_low(ccl), .cmp_aux_high(cah),
      .cmp_aux_low(cal), .irq(irq));
   // Clock at 100 MHz
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // One Avalon access; the read expectation is queued before the request goes out
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] e);
      int n;
      n = 0;
      if (!w) exp_q.push_back(e);
      @(posedge clk);
      adr <= a;
      wdat <= d;
      rd <= !w;
      wr <= w;
      do @(posedge clk); while (wrq !== 1'b0 && n++ < 50);
      if (wrq !== 1'b0) n_mismatch++;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus
   // Enables change the model at once; they only act at the next acquisition
   task automatic set_en(input logic [63:0] v);
      {e_ch, e_cl, e_ah, e_al} = v[35:0];
      bus(1'b1, fas_pkg::IDX_ENABLE_AUX, {24'h0, e_ah, e_al}, 34'h0);
      bus(1'b1, fas_pkg::IDX_ENABLE_CELL, {2'h0, e_ch, 2'h0, e_cl}, 34'h0);
   endtask : set_en
   // Faults settle one cycle before the done pulse; only the finishing bank is refreshed
   task automatic acq(input logic m, input logic [39:0] f);
      @(posedge clk);
      {aml, cah, cal, cch, ccl} <= f;
      @(posedge clk);
      md <= m;
      cd <= !m;
      if (m) f_ml = aml & e_al;
      else {f_ch, f_cl, f_ah, f_kl} = {cch & e_ch, ccl & e_cl, cah & e_ah, cal & e_al};
      @(posedge clk);
      md <= 1'b0;
      cd <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : acq
   task automatic rd_all;
      bus(1'b0, fas_pkg::IDX_AUX_LOW, 32'h0, {30'h0, f_ml});
      bus(1'b0, fas_pkg::IDX_CMP_CELL_HI, 32'h0, {20'h0, f_ch});
      bus(1'b0, fas_pkg::IDX_CMP_CELL_LO, 32'h0, {20'h0, f_cl});
      bus(1'b0, fas_pkg::IDX_CMP_AUX_HI, 32'h0, {30'h0, f_ah});
      bus(1'b0, fas_pkg::IDX_CMP_AUX_LO, 32'h0, {30'h0, f_kl});
   endtask : rd_all
   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : complete_run
   // Monitor takes the oldest note at every read answer
   always @(posedge clk) begin
      if (rd && wrq === 1'b0) chk({resp, rdat}, exp_q.pop_front());
   end
   initial begin
      #100us;
      n_mismatch++;
      complete_run;
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      {reset, rd, wr, md, cd, adr, wdat, aml, cah, cal, cch, ccl} = {5'h10, 80'h0};
      {f_ml, f_ah, f_kl, f_ch, f_cl} = 40'h0;
      {n_mismatch, check_count, seed} = {32'h0, 32'h0, 32'd89220};
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      rd_all;
      bus(1'b0, 8'h05, 32'h0, {2'b11, 32'h0});
      $display("test reset values done");
      set_en({64'hffff_ffff_ffff_ffff});
      bus(1'b1, fas_pkg::IDX_IRQ_MASK, 32'h1f, 34'h0);
      acq(1'b0, 40'h00_0000_4000);
      chk({33'h0, irq}, 34'h1);
      bus(1'b0, fas_pkg::IDX_IRQ_STATUS, 32'h0, 34'h2);
      repeat (3) @(posedge clk);
      chk({33'h0, irq}, 34'h0);
      bus(1'b1, fas_pkg::IDX_IRQ_MASK, 32'h0, 34'h0);
      acq(1'b1, 40'h10_0000_0000);
      chk({33'h0, irq}, 34'h0);
      bus(1'b0, fas_pkg::IDX_IRQ_STATUS, 32'h0, 34'h1);
      rd_all;
      $display("test interrupt done");
      for (int i = 0; i < 16; i++) begin
         r = {$random(seed), $random(seed)};
         set_en(r);
         r = {$random(seed), $random(seed)};
         acq(r[40], r[39:0]);
         bus(1'b1, 8'h0d + 8'(i % 5), r[63:32], 34'h0);
         rd_all;
      end
      $display("test random acquisitions done");
      complete_run;
   end
endmodule : fas_status_bank_tb_top
